// ---- src/fspc_pkg.sv ----
// Purpose: Constants for the flash self-programming control front-end
// Assumes: APB slave, byte registers in the low bits of 32-bit words
// Notes:   Offsets are word indices, byte address is index * 4 (printed offsets kept as indices)
package fspc_pkg;
    // ==========================================================
    // Register indices (byte address is index * 4)
    localparam logic [7:0]  IDX_CHIP_CTRL   = 8'h9F;
    localparam logic [7:0]  IDX_UPD_EN      = 8'hA5;
    localparam logic [7:0]  IDX_ADDR_LO     = 8'hA6;
    localparam logic [7:0]  IDX_ADDR_HI     = 8'hA7;
    localparam logic [7:0]  IDX_COMMAND     = 8'hAF;
    localparam logic [7:0]  IDX_TRIGGER     = 8'hA4;
    localparam logic [7:0]  IDX_KEY         = 8'hC7;
    localparam logic [7:0]  IDX_SETUP_BYTE  = 8'hC0;
    localparam logic [7:0]  IDX_BO_CTRL     = 8'hC1;
    localparam logic [7:0]  IDX_FLASH_STAT  = 8'hC2;
    // ==========================================================
    // Field positions
    localparam int BIT_PROG_EN    = 0;
    localparam int BIT_FAULT      = 6;
    localparam int BIT_APP_UEN    = 0;
    localparam int BIT_LDR_UEN    = 1;
    localparam int BIT_SETUP_UEN  = 2;
    localparam int BIT_SEC_UEN    = 3;
    localparam int BIT_SEC_MAP    = 4;
    localparam int BIT_BO_INHIBIT = 3;
    localparam int BIT_BO_DET_EN  = 0;
    localparam int BIT_BO_RST_EN  = 1;
    localparam int BIT_OPER_EN    = 5;
    localparam int BIT_CMD_CTRL   = 4;
    localparam int BIT_TRIGGER    = 0;
    // ==========================================================
    // Reset values and keys
    localparam logic [7:0] RST_COMMAND    = 8'h30;
    localparam logic [7:0] RST_UPD_EN     = 8'h00;
    localparam logic [7:0] RST_SETUP_BYTE = 8'hFF;
    localparam logic [7:0] KEY_FIRST      = 8'hAA;
    localparam logic [7:0] KEY_SECOND     = 8'h55;
    localparam logic [7:0] UPD_EN_MASK    = 8'h1F;
    // Function codes and region selects
    localparam logic [3:0] FC_READ    = 4'h0;
    localparam logic [3:0] FC_PROGRAM = 4'h1;
    localparam logic [3:0] FC_ERASE   = 4'h2;
    localparam logic [3:0] FC_UID     = 4'h4;
    localparam logic [3:0] FC_MAKER   = 4'hB;
    localparam logic [3:0] FC_DEVID   = 4'hC;
    localparam logic [1:0] RG_APP     = 2'h0;
    localparam logic [1:0] RG_LDR     = 2'h1;
    localparam logic [1:0] RG_SETUP   = 2'h3;
    localparam logic [1:0] RG_SECURE  = 2'h2;
    localparam int PAGE_BITS = 7;
    // ==========================================================
    // Timing: nominal erase and program times
    localparam int CLK_MHZ       = 100;
    localparam int ERASE_TIME_US = 5000;
    localparam int PROG_TIME_NS  = 23500;
    localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
    localparam int PROG_CYCLES   = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_CYCLES   = 1;
    localparam logic [7:0] SETUP_SIZE = 8'h06;
    // Key timer load after each key write; the key stays armed one cycle longer
    localparam logic [1:0] KEY_WINDOW = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CHECK = 3'b010,
        ST_BUSY  = 3'b100
    } fspc_state_e;
endpackage : fspc_pkg

// ---- src/fspc_ctrl.sv ----
// Purpose: Flash self-programming control front-end, APB register slave
// Assumes: Single clock, flash array timing modelled by a busy counter
// Notes:   Overview list below; registers sit at index * 4
//
// Overview of operation
// - Brown-out inhibit blocks erase/program under threshold while detection on and reset off
// - Trigger with oversize address sets fault flag
// - Trigger with invalid command sets fault flag
// - Erase/program of disabled region sets fault
// - Brown-out inhibited erase/program sets fault flag
// - Fault flag stays until software clears it
// - Chip control bit 0 enables self-programming
// - Enable turns internal RC oscillator on
// - Chip control write needs timed-access unlock
// - Update-enable bit 4 maps secure window
// - Bit 3 gates secure erase/program, key-protected
// - Bit 2 gates setup byte erase/program
// - Bit 1 gates loader erase/program
// - Bit 0 gates application erase/program
// - Update-enable register key-protected, resets zero
// - Command fields and reset value 0x30
// - Address high byte supplies bits 15:8
// - Address low byte supplies bits 7:0
// - Function codes and region selects decoded
// - Erase uses page-aligned address only
// - Trigger stalls cpu, clears on completion
`timescale 1ns/1ps
module fspc_ctrl import fspc_pkg::*; #(
    parameter int ERASE_CNT = ERASE_CYCLES,
    parameter int PROG_CNT  = PROG_CYCLES,
    parameter logic [15:0] APP_SIZE = 16'h8000,
    parameter logic [15:0] LDR_SIZE = 16'h1000,
    parameter logic [15:0] SEC_SIZE = 16'h0080
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        below_threshold,
    output logic             rc_osc_on,
    output logic             secure_window_map,
    output logic             cpu_stall,
    output logic             flash_erase,
    output logic             flash_program,
    output logic             flash_read,
    output logic      [15:0] flash_addr,
    output logic      [1:0]  flash_region
);
    // ==========================================================
    // Registers
    logic        prog_en_q, fault_q, boot_sel_q;
    logic [7:0]  upd_en_q, addr_lo_q, addr_hi_q, cmd_q, setup_q, bo_q;
    logic [1:0]  key_stage_q;
    logic [1:0]  key_timer_q;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q;
    logic        erase_q, prog_q, read_q, stall_q;
    logic [31:0] busy_cnt_q;
    fspc_state_e state_q;

    // ==========================================================
    // Bus decode; request taken in the access cycle, write lands at ready
    wire        acc     = psel && penable && !pready_q;
    wire        wr      = psel && penable && pready_q && pwrite;
    wire [9:0]  idx     = paddr[11:2];
    wire [7:0]  wbyte   = pwdata[7:0];
    wire        hit_cc  = idx == {2'b00, IDX_CHIP_CTRL};
    wire        hit_ue  = idx == {2'b00, IDX_UPD_EN};
    wire        hit_al  = idx == {2'b00, IDX_ADDR_LO};
    wire        hit_ah  = idx == {2'b00, IDX_ADDR_HI};
    wire        hit_cm  = idx == {2'b00, IDX_COMMAND};
    wire        hit_tg  = idx == {2'b00, IDX_TRIGGER};
    wire        hit_ky  = idx == {2'b00, IDX_KEY};
    wire        hit_sb  = idx == {2'b00, IDX_SETUP_BYTE};
    wire        hit_bo  = idx == {2'b00, IDX_BO_CTRL};
    wire        hit_st  = idx == {2'b00, IDX_FLASH_STAT};
    wire        mapped  = hit_cc | hit_ue | hit_al | hit_ah | hit_cm
                        | hit_tg | hit_ky | hit_sb | hit_bo | hit_st;
    // Unlocked: AA then 55 seen, window still open
    wire        unlocked = key_stage_q == 2'h2;
    wire        prot_ok  = unlocked && wr;
    // Any bus write outside the key register relocks the gate
    wire        key_wr   = wr && hit_ky;

    // ==========================================================
    // Command decode
    wire [1:0]  rsel    = cmd_q[7:6];
    wire        op_en   = cmd_q[BIT_OPER_EN];
    wire        ctl     = cmd_q[BIT_CMD_CTRL];
    wire [3:0]  fcode   = cmd_q[3:0];
    wire [15:0] taddr   = {addr_hi_q, addr_lo_q};
    wire        is_erase = op_en && !ctl && fcode == FC_ERASE;
    wire        is_prog  = op_en && !ctl && fcode == FC_PROGRAM;
    wire        is_read  = !op_en && !ctl && fcode == FC_READ;
    wire        is_id    = !op_en && !ctl && (fcode == FC_UID
                         || fcode == FC_MAKER || fcode == FC_DEVID);
    wire        modifies = is_erase || is_prog;
    wire        cmd_ok   = (is_erase || is_prog || is_read || is_id)
                         && (is_id || rsel != RG_SECURE
                             || upd_en_q[BIT_SEC_MAP]);
    // Region size limit, secure window reached through region 2
    wire [15:0] rsize = rsel == RG_APP ? APP_SIZE :
                        rsel == RG_LDR ? LDR_SIZE :
                        rsel == RG_SETUP ? {8'h00, SETUP_SIZE} : SEC_SIZE;
    wire        oversize = !is_id && taddr >= rsize;
    wire        region_en = rsel == RG_APP   ? upd_en_q[BIT_APP_UEN]
                          : rsel == RG_LDR   ? upd_en_q[BIT_LDR_UEN]
                          : rsel == RG_SETUP ? upd_en_q[BIT_SETUP_UEN]
                          : upd_en_q[BIT_SEC_UEN];
    wire        not_enabled = modifies && !region_en;
    // Inhibit only counts while detection on and reset off
    wire        bo_block = modifies && setup_q[BIT_BO_INHIBIT]
                         && bo_q[BIT_BO_DET_EN] && !bo_q[BIT_BO_RST_EN]
                         && below_threshold;
    wire        fault_now = !cmd_ok || oversize || not_enabled || bo_block;
    // Trigger only starts when enabled and unlocked
    wire        trig = prot_ok && hit_tg && wbyte[BIT_TRIGGER]
                     && prog_en_q && state_q == ST_IDLE;
    // Erase drops the offset within the 128-byte page
    wire [15:0] op_addr = is_erase
                        ? {taddr[15:PAGE_BITS], {PAGE_BITS{1'b0}}}
                        : taddr;
    wire [31:0] op_len = is_erase ? ERASE_CNT :
                         is_prog  ? PROG_CNT : READ_CYCLES;
    wire        done = state_q == ST_BUSY && busy_cnt_q == 32'h0;

    // ==========================================================
    // Read mux, reserved bits zero, trigger reads zero
    wire [7:0] rbyte =
        hit_cc ? {1'b0, fault_q, 4'h0, boot_sel_q, prog_en_q} :
        hit_ue ? upd_en_q : hit_al ? addr_lo_q : hit_ah ? addr_hi_q :
        hit_cm ? cmd_q : hit_sb ? setup_q : hit_bo ? bo_q :
        hit_st ? {5'h0, state_q} : 8'h00;

    // ==========================================================
    // Timed-access key sequencer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            key_stage_q <= 2'h0;
            key_timer_q <= 2'h0;
        end else if (key_wr && wbyte == KEY_FIRST) begin
            key_stage_q <= 2'h1;
            key_timer_q <= KEY_WINDOW;
        end else if (key_wr && wbyte == KEY_SECOND && key_stage_q == 2'h1) begin
            key_stage_q <= 2'h2;
            key_timer_q <= KEY_WINDOW;
        end else if (wr || key_timer_q == 2'h0) begin
            key_stage_q <= 2'h0;  // One protected write per unlock
            key_timer_q <= 2'h0;
        end else begin
            key_timer_q <= key_timer_q - 2'h1;
        end
    end

    // ==========================================================
    // Chip control: enable, fault flag (set wins over clear)
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prog_en_q  <= 1'b0;
            fault_q    <= 1'b0;
            boot_sel_q <= 1'b0;
        end else begin
            if (prot_ok && hit_cc) begin
                prog_en_q  <= wbyte[BIT_PROG_EN];
                boot_sel_q <= wbyte[1];
            end
            if (state_q == ST_CHECK && fault_now)
                fault_q <= 1'b1;
            else if (prot_ok && hit_cc)
                fault_q <= wbyte[BIT_FAULT];
        end
    end

    // ==========================================================
    // Plain and protected configuration registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            upd_en_q  <= RST_UPD_EN;
            addr_lo_q <= 8'h00;
            addr_hi_q <= 8'h00;
            cmd_q     <= RST_COMMAND;
            setup_q   <= RST_SETUP_BYTE;
            bo_q      <= 8'h00;
        end else begin
            if (prot_ok && hit_ue)
                upd_en_q <= wbyte & UPD_EN_MASK;
            if (wr && hit_al) addr_lo_q <= wbyte;
            if (wr && hit_ah) addr_hi_q <= wbyte;
            if (wr && hit_cm) cmd_q <= wbyte;
            if (wr && hit_sb) setup_q <= wbyte;
            if (wr && hit_bo) bo_q <= {6'h00, wbyte[1:0]};
        end
    end

    // ==========================================================
    // Operation sequencer: check one cycle, then busy for op time
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= ST_IDLE;
            busy_cnt_q <= 32'h0;
            erase_q    <= 1'b0;
            prog_q     <= 1'b0;
            read_q     <= 1'b0;
            stall_q    <= 1'b0;
        end else begin
            erase_q <= 1'b0;
            prog_q  <= 1'b0;
            read_q  <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (trig) begin
                        state_q <= ST_CHECK;
                        stall_q <= 1'b1;
                    end
                end
                ST_CHECK: begin
                    if (fault_now) begin
                        state_q <= ST_IDLE;
                        stall_q <= 1'b0;
                    end else begin
                        state_q    <= ST_BUSY;
                        busy_cnt_q <= op_len - 32'h1;
                        erase_q    <= is_erase;
                        prog_q     <= is_prog;
                        read_q     <= is_read || is_id;
                    end
                end
                ST_BUSY: begin
                    if (done) begin
                        state_q <= ST_IDLE;
                        stall_q <= 1'b0;
                    end else begin
                        busy_cnt_q <= busy_cnt_q - 32'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    stall_q <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Outputs straight from flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q          <= 32'h0;
            pready_q          <= 1'b0;
            pslverr_q         <= 1'b0;
            rc_osc_on         <= 1'b0;
            secure_window_map <= 1'b0;
            flash_addr        <= 16'h0000;
            flash_region      <= 2'h0;
        end else begin
            pready_q          <= acc;
            pslverr_q         <= acc && !mapped;
            prdata_q          <= acc ? {24'h0, rbyte} : 32'h0;
            rc_osc_on         <= prog_en_q;
            secure_window_map <= upd_en_q[BIT_SEC_MAP];
            if (state_q == ST_CHECK) begin
                flash_addr   <= op_addr;
                flash_region <= rsel;
            end
        end
    end

    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign cpu_stall     = stall_q;
    assign flash_erase   = erase_q;
    assign flash_program = prog_q;
    assign flash_read    = read_q;

    // ==========================================================
    // Checks
    fault_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
        fault_q && !(prot_ok && hit_cc) |=> fault_q)
        else $error("fault flag dropped without write");
    fault_region_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_CHECK && not_enabled |=> fault_q && state_q == ST_IDLE)
        else $error("disabled region did not fault");
    no_trig_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_IDLE && !prog_en_q |=> state_q == ST_IDLE)
        else $error("start while disabled");
    osc_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(prog_en_q) |=> rc_osc_on)
        else $error("oscillator not on");
    lock_cc_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr && hit_cc && !unlocked |=> $stable(prog_en_q))
        else $error("locked write changed enable");
    lock_ue_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr && hit_ue && !unlocked |=> $stable(upd_en_q))
        else $error("locked write changed update enable");
    erase_page_a: assert property (@(posedge mclk) disable iff (!rst_n)
        flash_erase |-> flash_addr[6:0] == 7'h00)
        else $error("erase address not page aligned");
    bo_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == ST_CHECK && bo_block |=> !flash_erase && !flash_program)
        else $error("brown-out did not block");
    stall_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
        done |=> !cpu_stall)
        else $error("stall not released");
    erase_run_c: cover property (@(posedge mclk) disable iff (!rst_n)
        flash_erase);
    prog_run_c: cover property (@(posedge mclk) disable iff (!rst_n)
        flash_program);
    fault_set_c: cover property (@(posedge mclk) disable iff (!rst_n)
        $rose(fault_q));
endmodule : fspc_ctrl

// ---- testbench/test_flash_self_programming_control.sv ----
// Purpose: Self-checking bench for the flash self-programming front-end
// Assumes: APB master with one request in flight, short busy counts
// Notes:   Driver queues expected results, two monitors compare them
`timescale 1ns/1ps
module test_flash_self_programming_control import fspc_pkg::*; ;
    // ==========================================================
    // Signals and scoreboard state
    logic        mclk, rst_n, psel, penable, pwrite, below_threshold;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready, pslverr, rc_osc_on, secure_window_map, cpu_stall;
    wire         flash_erase, flash_program, flash_read;
    wire  [15:0] flash_addr;
    wire  [1:0]  flash_region;
    logic [32:0] rd_q[$];
    logic [32:0] op_q[$];
    logic [32:0] got_exp;
    logic        fault_m;
    int          num_errors;
    int          comparisons;

    // Short busy counts keep the run brief
    fspc_ctrl #(.ERASE_CNT(20), .PROG_CNT(5)) dut (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .below_threshold(below_threshold), .rc_osc_on(rc_osc_on),
        .secure_window_map(secure_window_map), .cpu_stall(cpu_stall),
        .flash_erase(flash_erase), .flash_program(flash_program),
        .flash_read(flash_read), .flash_addr(flash_addr),
        .flash_region(flash_region)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ==========================================================
    // Comparison, verdict and bus tasks
    task automatic check(input string what, input logic [32:0] seen,
                         input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // Entered right after an edge; returns at the completing edge
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] data);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, data};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
    endtask : apb

    task automatic idle();
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : idle

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                      input logic err);
        rd_q.push_back({err, 24'h000000, exp});
        apb(1'b0, idx, 8'h00);
    endtask : rd

    // Key pair written back to back so the unlock is still armed
    task automatic pw(input logic [7:0] idx, input logic [7:0] data);
        apb(1'b1, IDX_KEY, KEY_FIRST);
        apb(1'b1, IDX_KEY, KEY_SECOND);
        apb(1'b1, idx, data);
    endtask : pw

    // Bounded wait on the stall level, which brackets every operation
    task automatic wait_stall(input logic val);
        int n;
        n = 0;
        while (cpu_stall !== val && n < 200) begin
            @(posedge mclk);
            n++;
        end
        check("cpu_stall", cpu_stall, val);
    endtask : wait_stall

    // kind is {erase, program, read}; a faulting op must start nothing
    task automatic run_op(input logic [7:0] cmd, input logic [7:0] ah,
                          input logic [7:0] al, input logic flt,
                          input logic [2:0] kind);
        apb(1'b1, IDX_COMMAND, cmd);
        apb(1'b1, IDX_ADDR_LO, al);
        apb(1'b1, IDX_ADDR_HI, ah);
        if (!flt) begin
            op_q.push_back({kind, cmd[7:6], ah,
                            kind[2] ? (al & 8'h80) : al});
        end
        fault_m = fault_m | flt;
        pw(IDX_TRIGGER, 8'h01);
        idle();
        wait_stall(1'b1);
        wait_stall(1'b0);
        rd(IDX_CHIP_CTRL, {1'b0, fault_m, 6'h01}, 1'b0);
    endtask : run_op

    task automatic clear_fault();
        pw(IDX_CHIP_CTRL, 8'h01);
        fault_m = 1'b0;
    endtask : clear_fault

    // ==========================================================
    // Monitors: each result takes the oldest note off its queue
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            got_exp = rd_q.size() > 0 ? rd_q.pop_front() : 'x;
            check("read", {pslverr, prdata}, got_exp);
        end
        if ((flash_erase | flash_program | flash_read) === 1'b1) begin
            got_exp = op_q.size() > 0 ? op_q.pop_front() : 'x;
            check("flash op", {12'h000, flash_erase, flash_program,
                  flash_read, flash_region, flash_addr}, got_exp);
        end
    end

    // Whole run is well under a thousand cycles; this span of 30000 cycles is over thirty times that
    initial begin
        #300000;
        num_errors++;
        wrap_up();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] ra, rb;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        below_threshold = 1'b0;
        fault_m = 1'b0;
        num_errors = 0;
        comparisons = 0;
        void'($urandom(53));
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(IDX_UPD_EN, RST_UPD_EN, 1'b0);
        rd(IDX_ADDR_LO, 8'h00, 1'b0);
        rd(IDX_ADDR_HI, 8'h00, 1'b0);
        rd(IDX_COMMAND, RST_COMMAND, 1'b0);
        rd(IDX_SETUP_BYTE, RST_SETUP_BYTE, 1'b0);
        rd(8'h10, 8'h00, 1'b1);
        // Trigger while disabled starts nothing
        apb(1'b1, IDX_COMMAND, 8'h00);
        pw(IDX_TRIGGER, 8'h01);
        idle();
        repeat (4) @(posedge mclk);
        check("stall off", cpu_stall, 1'b0);
        // Plain write refused; an unrelated write relocks the key
        apb(1'b1, IDX_CHIP_CTRL, 8'h01);
        apb(1'b1, IDX_UPD_EN, 8'h1F);
        apb(1'b1, IDX_KEY, KEY_FIRST);
        apb(1'b1, IDX_KEY, KEY_SECOND);
        apb(1'b1, IDX_COMMAND, RST_COMMAND);
        apb(1'b1, IDX_CHIP_CTRL, 8'h01);
        rd(IDX_CHIP_CTRL, 8'h00, 1'b0);
        rd(IDX_UPD_EN, 8'h00, 1'b0);
        pw(IDX_CHIP_CTRL, 8'h01);
        pw(IDX_UPD_EN, 8'h1F);
        rd(IDX_UPD_EN, 8'h1F, 1'b0);
        idle();
        repeat (2) @(posedge mclk);
        check("rc osc on", rc_osc_on, 1'b1);
        check("window map", secure_window_map, 1'b1);
        // Every region; read, program, erase and device ID codes, random page offsets
        ra = 8'($urandom_range(127));
        rb = 8'($urandom);
        run_op(8'h22, ra, rb, 1'b0, 3'b100);
        run_op(8'h61, ra & 8'h0F, rb, 1'b0, 3'b010);
        run_op(8'hC0, 8'h00, 8'h02, 1'b0, 3'b001);
        run_op(8'hE1, 8'h00, 8'h05, 1'b0, 3'b010);
        run_op(8'hA2, 8'h00, rb & 8'h7F, 1'b0, 3'b100);
        run_op(8'h00, ra, rb, 1'b0, 3'b001);
        run_op(8'h0C, 8'hFF, 8'hFF, 1'b0, 3'b001);
        run_op(8'h21, 8'h80, 8'h00, 1'b1, 3'b000);
        run_op(8'h21, ra, rb, 1'b0, 3'b010);
        clear_fault();
        run_op(8'h2F, ra, rb, 1'b1, 3'b000);
        clear_fault();
        // Brown-out inhibit with detection on and reset off
        apb(1'b1, IDX_BO_CTRL, 8'h01);
        below_threshold <= 1'b1;
        run_op(8'h21, ra, rb, 1'b1, 3'b000);
        clear_fault();
        apb(1'b1, IDX_SETUP_BYTE, 8'hF7);
        run_op(8'h21, ra, rb, 1'b0, 3'b010);
        below_threshold <= 1'b0;
        // Regions locked again; window back to application memory
        pw(IDX_UPD_EN, 8'h00);
        run_op(8'h62, 8'h00, rb, 1'b1, 3'b000);
        check("window map", secure_window_map, 1'b0);
        clear_fault();
        pw(IDX_CHIP_CTRL, 8'h00);
        idle();
        repeat (2) @(posedge mclk);
        check("rc osc off", rc_osc_on, 1'b0);
        check("pending", 33'(rd_q.size() + op_q.size()), 33'h0);
        wrap_up();
    end
endmodule : test_flash_self_programming_control
